// ---- logic/frs_gpi_filter.sv ----
/*
  Conditioning of the fifth auxiliary input used as a logic input:
  a level is accepted only after it has stood for FILTER_CYC cycles.
  Assumes the raw input is synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "frs_regs.svh"

module frs_gpi_filter
  import frs_pkg::*;
#(
  parameter int FILTER_CYC = `FRS_GPI_FILTER_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw and conditioned level
  input wire logic raw_in,
  output logic clean_q
);

  localparam int CW = (FILTER_CYC < 2) ? 1 : $clog2(FILTER_CYC + 1);

  logic [CW-1:0] cnt_q;

  // Counter cannot serve a zero-length filter
  if (FILTER_CYC < 1) begin : g_chk
    $error("FILTER_CYC must be at least 1");
  end

  // Count stable cycles of a differing level, accept on reaching the limit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      clean_q <= 1'b0;
    end else if (raw_in == clean_q) begin
      cnt_q <= '0;
    end else if (cnt_q == CW'(FILTER_CYC - 1)) begin
      cnt_q <= '0;
      clean_q <= raw_in; // RULE3
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

endmodule : frs_gpi_filter
`default_nettype wire

// ---- logic/frs_pkg.sv ----
/*
  Types shared by the fault status readback bank.
  Assumes frs_regs.svh supplies the numeric constants.
*/
package frs_pkg;

  // Fault record memory fill state, Gray coded along its path
  typedef enum logic [1:0] {
    FRS_PTR_EMPTY = 2'b00,
    FRS_PTR_FILLING = 2'b01,
    FRS_PTR_FULLST = 2'b11
  } frs_ptr_state_t;

  typedef logic [7:0] frs_byte_t;

endpackage : frs_pkg

// ---- logic/frs_record_pointer.sv ----
/*
  Next fault record pointer: low byte of the record address.
  Assumes record_done pulses once per completed record write and
  erase_done pulses once when the record memory has been erased.
*/
`timescale 1ns/1ps
`default_nettype none
`include "frs_regs.svh"

module frs_record_pointer
  import frs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Record writer events
  input wire logic record_done,
  input wire logic erase_done,
  // Pointer state
  output frs_byte_t ptr_q,
  output logic full_q
);

  frs_ptr_state_t state_q;

  // Fill state follows writes; erase restarts from empty
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= FRS_PTR_EMPTY;
      ptr_q <= `FRS_PTR_START; // RULE6
      full_q <= 1'b0;
    end else if (erase_done) begin
      state_q <= FRS_PTR_EMPTY;
      ptr_q <= `FRS_PTR_START; // RULE6
      full_q <= 1'b0;
    end else if (record_done) begin
      case (state_q)
        FRS_PTR_EMPTY, FRS_PTR_FILLING: begin
          if (ptr_q == `FRS_PTR_LAST) begin // RULE7
            state_q <= FRS_PTR_FULLST;
            ptr_q <= `FRS_PTR_FULL; // RULE8
            full_q <= 1'b1;
          end else begin
            state_q <= FRS_PTR_FILLING;
            ptr_q <= ptr_q + `FRS_PTR_STEP; // RULE6
          end
        end
        default: begin
          ptr_q <= `FRS_PTR_FULL; // RULE8
        end
      endcase
    end
  end

endmodule : frs_record_pointer
`default_nettype wire

// ---- logic/frs_regs.svh ----
/*
  Register offsets, field positions, reset values and timing counts
  of the fault status readback bank.
  Assumes inclusion by bare name from every file that needs them.
*/
`ifndef FRS_REGS_SVH
`define FRS_REGS_SVH

// Register offsets on the management register port
`define FRS_OFF_STATUS_FOUR 8'hEF
`define FRS_OFF_STATUS_FIVE 8'hF0
`define FRS_OFF_NEXT_PTR 8'hF1
`define FRS_OFF_REVISION 8'hF5

// Status four fields
`define FRS_S4_AUX2_BIT 7
`define FRS_S4_AUX1_BIT 6
`define FRS_S4_HIGH_BIT 5
`define FRS_S4_PRI4_BIT 4
`define FRS_S4_PRI3_BIT 3
`define FRS_S4_PRI2_BIT 2
`define FRS_S4_PRI1_BIT 1
`define FRS_S4_AUX5_GPI_BIT 0

// Status five fields; bits 7:3 reserved
`define FRS_S5_AUX5_BIT 2
`define FRS_S5_AUX4_BIT 1
`define FRS_S5_AUX3_BIT 0
`define FRS_S5_RSVD_VAL 5'h00

// Revision fields
`define FRS_REV_FAMILY_MSB 7
`define FRS_REV_FAMILY_LSB 4
`define FRS_REV_HW_MSB 3
`define FRS_REV_HW_LSB 0

// Next record pointer values
`define FRS_PTR_START 8'h80
`define FRS_PTR_STEP 8'h08
`define FRS_PTR_LAST 8'hF8
`define FRS_PTR_FULL 8'h00

// Coordination bus address range; zero is broadcast
`define FRS_COORD_MIN 4'h1
`define FRS_COORD_MAX 4'h4

// Reset value of the read data and value returned by unmapped offsets
`define FRS_RDATA_RST 8'h00
`define FRS_UNMAPPED_VAL 8'h00

// Timing: clock period and input conditioning time
`define FRS_CLK_PERIOD_NS 10
`define FRS_GPI_FILTER_NS 40
`define FRS_GPI_FILTER_CYC \
  (((`FRS_GPI_FILTER_NS) + (`FRS_CLK_PERIOD_NS) - 1) / (`FRS_CLK_PERIOD_NS))

`endif

// ---- logic/frs_top.sv ----
/*
  Fault status readback bank: read-only limit status, conditioned
  logic input, next fault record pointer and revision identifier,
  plus the coordination bus address check.
  Assumes comparator results, limit sense settings and record writer
  events arrive synchronous to SYS_CLK; the management bus protocol
  sits outside and presents a register offset with a read strobe.
*/
// Functional notes
// (RULE1) Limit flags for high rail, four primary rails, aux3 follow sense A.
// (RULE2) Aux4 and aux5 limit flags sit in status five, following sense B.
// (RULE3) Status four bit 0 shows aux5 logic input after conditioning.
// (RULE4) Status five bits 7:3 are reserved and carry no function.
// (RULE5) Pointer byte is low byte of next record address in record area.
// (RULE6) Pointer starts at 0x80 when empty and steps by eight per record.
// (RULE7) Pointer reads 0xF8 when exactly one record slot is left.
// (RULE8) Pointer reads zero once the record memory is full.
// (RULE9) Read-only revision register distinguishes this part from compatibles.
// (RULE10) Revision upper nibble holds the fixed four-bit family identifier.
// (RULE11) Revision lower nibble holds the hardware revision number.
// (RULE12) Each coordination bus device uses its own unique address.
// (RULE13) Coordination address is independent of management address straps.
// (RULE14) Only coordination addresses 1 to 4 are accepted; zero is broadcast.
// (RULE15) Reads of these registers have no side effect on contents or writes.
`timescale 1ns/1ps
`default_nettype none
`include "frs_regs.svh"

module frs_top
  import frs_pkg::*;
#(
  // Family identifier, value arbitrary
  parameter logic [3:0] FAMILY_ID = 4'h5,
  // Hardware revision number, value arbitrary
  parameter logic [3:0] HW_REVISION = 4'h1,
  // Conditioning length of the logic input in cycles
  parameter int GPI_FILTER_CYC = `FRS_GPI_FILTER_CYC
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Comparator results, 1 while the reading is above its limit
  input wire logic HIGH_RAIL_ABOVE,
  input wire logic PRIMARY_RAIL1_ABOVE,
  input wire logic PRIMARY_RAIL2_ABOVE,
  input wire logic PRIMARY_RAIL3_ABOVE,
  input wire logic PRIMARY_RAIL4_ABOVE,
  input wire logic AUX_INPUT1_ABOVE,
  input wire logic AUX_INPUT2_ABOVE,
  input wire logic AUX_INPUT3_ABOVE,
  input wire logic AUX_INPUT4_ABOVE,
  input wire logic AUX_INPUT5_ABOVE,
  // Limit sense settings, 1 flags above limit, 0 flags below
  input wire logic LIMIT_SENSE_SELECT_A,
  input wire logic LIMIT_SENSE_SELECT_B,
  // Raw fifth auxiliary input used as a logic input
  input wire logic AUX_INPUT5_RAW,
  // Record writer events
  input wire logic RECORD_WRITTEN,
  input wire logic RECORD_ERASED,
  // Coordination bus address setting
  input wire logic [3:0] COORD_ADDR_CFG,
  // Register read port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  // Pointer and coordination status
  output logic RECORD_MEM_FULL,
  output logic [3:0] COORD_BUS_ADDRESS,
  output logic COORD_ADDR_VALID
);

  // Limit flags, registered
  logic high_rail_limit_flag_q;
  logic primary_rail1_limit_flag_q;
  logic primary_rail2_limit_flag_q;
  logic primary_rail3_limit_flag_q;
  logic primary_rail4_limit_flag_q;
  logic aux_input1_limit_flag_q;
  logic aux_input2_limit_flag_q;
  logic aux_input3_limit_flag_q;
  logic aux_input4_limit_flag_q;
  logic aux_input5_limit_flag_q;

  // Conditioned logic input and pointer
  logic aux_input5_logic_state;
  frs_byte_t next_record_pointer;
  logic ptr_full;

  // Register images
  frs_byte_t black_box_status_four;
  frs_byte_t black_box_status_five;
  frs_byte_t revision_identifier;
  frs_byte_t rdata_d;

  // Coordination address state
  logic [3:0] coord_addr_d;
  logic coord_valid_d;

  // Filter length that the conditioning counter cannot serve
  if (GPI_FILTER_CYC < 1) begin : g_chk_filter
    $error("GPI_FILTER_CYC must be at least 1");
  end

  // Apply the selected sense: above or below the limit
  function automatic logic sense_apply(input logic above, input logic sense);
    sense_apply = sense ? above : ~above;
  endfunction : sense_apply

  // Address in the accepted coordination range
  function automatic logic coord_in_range(input logic [3:0] a);
    coord_in_range = (a >= `FRS_COORD_MIN) && (a <= `FRS_COORD_MAX);
  endfunction : coord_in_range

  // Flags under the first sense setting
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      high_rail_limit_flag_q <= 1'b0;
      primary_rail1_limit_flag_q <= 1'b0;
      primary_rail2_limit_flag_q <= 1'b0;
      primary_rail3_limit_flag_q <= 1'b0;
      primary_rail4_limit_flag_q <= 1'b0;
      aux_input1_limit_flag_q <= 1'b0;
      aux_input2_limit_flag_q <= 1'b0;
      aux_input3_limit_flag_q <= 1'b0;
    end else begin
      high_rail_limit_flag_q <= sense_apply(HIGH_RAIL_ABOVE, LIMIT_SENSE_SELECT_A); // RULE1
      primary_rail1_limit_flag_q <= sense_apply(PRIMARY_RAIL1_ABOVE, LIMIT_SENSE_SELECT_A); // RULE1
      primary_rail2_limit_flag_q <= sense_apply(PRIMARY_RAIL2_ABOVE, LIMIT_SENSE_SELECT_A); // RULE1
      primary_rail3_limit_flag_q <= sense_apply(PRIMARY_RAIL3_ABOVE, LIMIT_SENSE_SELECT_A); // RULE1
      primary_rail4_limit_flag_q <= sense_apply(PRIMARY_RAIL4_ABOVE, LIMIT_SENSE_SELECT_A); // RULE1
      aux_input1_limit_flag_q <= sense_apply(AUX_INPUT1_ABOVE, LIMIT_SENSE_SELECT_A);
      aux_input2_limit_flag_q <= sense_apply(AUX_INPUT2_ABOVE, LIMIT_SENSE_SELECT_A);
      aux_input3_limit_flag_q <= sense_apply(AUX_INPUT3_ABOVE, LIMIT_SENSE_SELECT_A); // RULE1
    end
  end

  // Flags under the second sense setting
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      aux_input4_limit_flag_q <= 1'b0;
      aux_input5_limit_flag_q <= 1'b0;
    end else begin
      aux_input4_limit_flag_q <= sense_apply(AUX_INPUT4_ABOVE, LIMIT_SENSE_SELECT_B); // RULE2
      aux_input5_limit_flag_q <= sense_apply(AUX_INPUT5_ABOVE, LIMIT_SENSE_SELECT_B); // RULE2
    end
  end

  // Logic input conditioning
  frs_gpi_filter #(
    .FILTER_CYC(GPI_FILTER_CYC)
  ) u_gpi_filter (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .raw_in(AUX_INPUT5_RAW),
    .clean_q(aux_input5_logic_state)
  );

  // Next record pointer, advanced only by the record writer
  frs_record_pointer u_record_pointer (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .record_done(RECORD_WRITTEN),
    .erase_done(RECORD_ERASED),
    .ptr_q(next_record_pointer),
    .full_q(ptr_full)
  );

  // Status four image
  always_comb begin
    black_box_status_four = 8'h00;
    black_box_status_four[`FRS_S4_AUX2_BIT] = aux_input2_limit_flag_q;
    black_box_status_four[`FRS_S4_AUX1_BIT] = aux_input1_limit_flag_q;
    black_box_status_four[`FRS_S4_HIGH_BIT] = high_rail_limit_flag_q; // RULE1
    black_box_status_four[`FRS_S4_PRI4_BIT] = primary_rail4_limit_flag_q; // RULE1
    black_box_status_four[`FRS_S4_PRI3_BIT] = primary_rail3_limit_flag_q; // RULE1
    black_box_status_four[`FRS_S4_PRI2_BIT] = primary_rail2_limit_flag_q; // RULE1
    black_box_status_four[`FRS_S4_PRI1_BIT] = primary_rail1_limit_flag_q; // RULE1
    black_box_status_four[`FRS_S4_AUX5_GPI_BIT] = aux_input5_logic_state; // RULE3
  end

  // Status five image, reserved bits held at zero
  always_comb begin
    black_box_status_five = {`FRS_S5_RSVD_VAL, 3'h0}; // RULE4
    black_box_status_five[`FRS_S5_AUX5_BIT] = aux_input5_limit_flag_q; // RULE2
    black_box_status_five[`FRS_S5_AUX4_BIT] = aux_input4_limit_flag_q; // RULE2
    black_box_status_five[`FRS_S5_AUX3_BIT] = aux_input3_limit_flag_q; // RULE1
  end

  // Revision image: family nibble over hardware revision
  always_comb begin
    revision_identifier = 8'h00; // RULE9
    revision_identifier[`FRS_REV_FAMILY_MSB:`FRS_REV_FAMILY_LSB] = FAMILY_ID; // RULE10
    revision_identifier[`FRS_REV_HW_MSB:`FRS_REV_HW_LSB] = HW_REVISION; // RULE11
  end

  // Read decode; unmapped offsets return zero
  always_comb begin
    if (REG_ADDR == `FRS_OFF_STATUS_FOUR) begin
      rdata_d = black_box_status_four;
    end else if (REG_ADDR == `FRS_OFF_STATUS_FIVE) begin
      rdata_d = black_box_status_five;
    end else if (REG_ADDR == `FRS_OFF_NEXT_PTR) begin
      rdata_d = next_record_pointer; // RULE5
    end else if (REG_ADDR == `FRS_OFF_REVISION) begin
      rdata_d = revision_identifier; // RULE9
    end else begin
      rdata_d = `FRS_UNMAPPED_VAL;
    end
  end

  // Read answer one cycle after the strobe; data holds until next read
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      REG_RDATA <= `FRS_RDATA_RST;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= rdata_d; // RULE15
      end
    end
  end

  // Memory full status mirrors the pointer state
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      RECORD_MEM_FULL <= 1'b0;
    end else begin
      RECORD_MEM_FULL <= ptr_full; // RULE8
    end
  end

  // Coordination address check, independent of any strap input
  always_comb begin
    coord_valid_d = coord_in_range(COORD_ADDR_CFG); // RULE14
    coord_addr_d = coord_valid_d ? COORD_ADDR_CFG : 4'h0; // RULE13
  end

  // Own coordination address, zero while the setting is invalid
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      COORD_BUS_ADDRESS <= 4'h0;
      COORD_ADDR_VALID <= 1'b0;
    end else begin
      COORD_BUS_ADDRESS <= coord_addr_d; // RULE12
      COORD_ADDR_VALID <= coord_valid_d; // RULE14
    end
  end

endmodule : frs_top
`default_nettype wire

// ---- sim/frs_top_assertions.sv ----
/*
  Port checker of the fault status readback bank.
  Assumes a bind onto frs_top and the shared register header.
*/
`timescale 1ns/1ps
`default_nettype none
`include "frs_regs.svh"

module frs_top_assertions
  import frs_pkg::*;
#(
  parameter logic [3:0] FAMILY_ID = 4'h5,
  parameter logic [3:0] HW_REVISION = 4'h1
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Comparators and senses
  input wire logic HIGH_RAIL_ABOVE,
  input wire logic PRIMARY_RAIL1_ABOVE,
  input wire logic PRIMARY_RAIL2_ABOVE,
  input wire logic PRIMARY_RAIL3_ABOVE,
  input wire logic PRIMARY_RAIL4_ABOVE,
  input wire logic AUX_INPUT1_ABOVE,
  input wire logic AUX_INPUT2_ABOVE,
  input wire logic AUX_INPUT3_ABOVE,
  input wire logic AUX_INPUT4_ABOVE,
  input wire logic AUX_INPUT5_ABOVE,
  input wire logic LIMIT_SENSE_SELECT_A,
  input wire logic LIMIT_SENSE_SELECT_B,
  // Events and settings
  input wire logic RECORD_WRITTEN,
  input wire logic RECORD_ERASED,
  input wire logic [3:0] COORD_ADDR_CFG,
  // Read port and status
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_RVALID,
  input wire logic RECORD_MEM_FULL,
  input wire logic [3:0] COORD_BUS_ADDRESS,
  input wire logic COORD_ADDR_VALID
);
  logic [15:0] vec;
  logic [15:0] vec_q;
  logic [1:0] st_q;

  // Level inputs gathered to detect a settled state
  assign vec = {LIMIT_SENSE_SELECT_A, LIMIT_SENSE_SELECT_B, COORD_ADDR_CFG,
    HIGH_RAIL_ABOVE, PRIMARY_RAIL1_ABOVE, PRIMARY_RAIL2_ABOVE, PRIMARY_RAIL3_ABOVE,
    PRIMARY_RAIL4_ABOVE, AUX_INPUT1_ABOVE, AUX_INPUT2_ABOVE, AUX_INPUT3_ABOVE,
    AUX_INPUT4_ABOVE, AUX_INPUT5_ABOVE};

  // Counts edges with inputs unchanged, saturating at three
  always_ff @(posedge SYS_CLK) begin
    vec_q <= vec;
    if (!RST_N || vec != vec_q) st_q <= 2'h0;
    else if (st_q != 2'h3) st_q <= st_q + 2'h1;
  end

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_rd(logic [7:0] a);
    REG_RD && REG_ADDR == a;
  endsequence
  sequence s_rd_st(logic [7:0] a);
    st_q == 2'h3 ##0 s_rd(a);
  endsequence

  AST_RD_ANSWER: assert property (REG_RD |=> REG_RVALID)
    else $error("read not answered");
  AST_RD_QUIET: assert property (!REG_RD |=> !REG_RVALID && $stable(REG_RDATA))
    else $error("read data moved without a read");
  AST_REV: assert property (s_rd(`FRS_OFF_REVISION) |=>
    REG_RDATA == {FAMILY_ID, HW_REVISION}) else $error("revision byte wrong");
  AST_S5_RSVD: assert property (s_rd(`FRS_OFF_STATUS_FIVE) |=>
    REG_RDATA[7:3] == 5'h00) else $error("status five reserved bits set");
  AST_S5_FLAGS: assert property (s_rd_st(`FRS_OFF_STATUS_FIVE) |=> REG_RDATA[2:0] ==
    ($past({AUX_INPUT5_ABOVE, AUX_INPUT4_ABOVE, AUX_INPUT3_ABOVE}) ~^ $past(
    {LIMIT_SENSE_SELECT_B, LIMIT_SENSE_SELECT_B, LIMIT_SENSE_SELECT_A})))
    else $error("status five flags wrong");
  AST_S4_FLAGS: assert property (s_rd_st(`FRS_OFF_STATUS_FOUR) |=> REG_RDATA[7:1] ==
    ($past({AUX_INPUT2_ABOVE, AUX_INPUT1_ABOVE, HIGH_RAIL_ABOVE, PRIMARY_RAIL4_ABOVE,
    PRIMARY_RAIL3_ABOVE, PRIMARY_RAIL2_ABOVE, PRIMARY_RAIL1_ABOVE}) ~^
    {7{$past(LIMIT_SENSE_SELECT_A)}})) else $error("status four flags wrong");
  AST_ERASE_CLEARS: assert property (RECORD_ERASED |=> ##1 !RECORD_MEM_FULL)
    else $error("full kept after erase");
  AST_FULL_HOLDS: assert property (RECORD_MEM_FULL && !RECORD_ERASED &&
    !$past(RECORD_ERASED) |=> RECORD_MEM_FULL) else $error("full dropped");
  AST_FULL_CAUSE: assert property ($rose(RECORD_MEM_FULL) |-> $past(RECORD_WRITTEN, 2))
    else $error("full without a write");
  AST_COORD_OK: assert property (st_q == 2'h3 && COORD_ADDR_CFG inside {[4'h1:4'h4]}
    |=> COORD_ADDR_VALID && COORD_BUS_ADDRESS == $past(COORD_ADDR_CFG))
    else $error("legal address refused");
  AST_COORD_BAD: assert property (st_q == 2'h3 && !(COORD_ADDR_CFG inside {[4'h1:4'h4]})
    |=> !COORD_ADDR_VALID && COORD_BUS_ADDRESS == 4'h0) else $error("bad address taken");
endmodule : frs_top_assertions
`default_nettype wire

// ---- sim/tb.sv ----
/*
  Self-checking bench of the fault status readback bank.
  Assumes the design files and the checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "frs_regs.svh"

module tb;
  import frs_pkg::*;
  // Identity values, arbitrary
  localparam logic [3:0] FAM_ID = 4'hA;
  localparam logic [3:0] HW_REV = 4'h3;
  localparam int FILT = 4;
  typedef struct packed {
    logic [1:0] sense;
    logic [9:0] above;
    logic [7:0] s4;
    logic [7:0] s5;
  } frs_row_t;
  // Senses, comparators high..aux5, expected status four and five
  frs_row_t rows [5] = '{'{2'b11, 10'h000, 8'h00, 8'h00}, '{2'b00, 10'h000, 8'hFE, 8'h07},
    '{2'b10, 10'h202, 8'h20, 8'h04}, '{2'b01, 10'h14D, 8'h74, 8'h04},
    '{2'b11, 10'h002, 8'h00, 8'h02}};
  logic SYS_CLK, RST_N, REG_RD, RECORD_WRITTEN, RECORD_ERASED, AUX_INPUT5_RAW;
  logic HIGH_RAIL_ABOVE, PRIMARY_RAIL1_ABOVE, PRIMARY_RAIL2_ABOVE, PRIMARY_RAIL3_ABOVE;
  logic PRIMARY_RAIL4_ABOVE, AUX_INPUT1_ABOVE, AUX_INPUT2_ABOVE, AUX_INPUT3_ABOVE;
  logic AUX_INPUT4_ABOVE, AUX_INPUT5_ABOVE, LIMIT_SENSE_SELECT_A, LIMIT_SENSE_SELECT_B;
  logic REG_RVALID, RECORD_MEM_FULL, COORD_ADDR_VALID;
  logic [3:0] COORD_ADDR_CFG, COORD_BUS_ADDRESS;
  logic [7:0] REG_ADDR, REG_RDATA;
  logic [9:0] above_v;
  logic [1:0] sense_v;
  int n_fail = 0;
  int samples_checked = 0;

  // Grouped stimulus fanned out to the ports
  assign {HIGH_RAIL_ABOVE, PRIMARY_RAIL1_ABOVE, PRIMARY_RAIL2_ABOVE, PRIMARY_RAIL3_ABOVE,
    PRIMARY_RAIL4_ABOVE, AUX_INPUT1_ABOVE, AUX_INPUT2_ABOVE, AUX_INPUT3_ABOVE,
    AUX_INPUT4_ABOVE, AUX_INPUT5_ABOVE} = above_v;
  assign {LIMIT_SENSE_SELECT_A, LIMIT_SENSE_SELECT_B} = sense_v;

  frs_top #(.FAMILY_ID(FAM_ID), .HW_REVISION(HW_REV), .GPI_FILTER_CYC(FILT)) dut_u (
    .SYS_CLK, .RST_N, .HIGH_RAIL_ABOVE, .PRIMARY_RAIL1_ABOVE, .PRIMARY_RAIL2_ABOVE,
    .PRIMARY_RAIL3_ABOVE, .PRIMARY_RAIL4_ABOVE, .AUX_INPUT1_ABOVE, .AUX_INPUT2_ABOVE,
    .AUX_INPUT3_ABOVE, .AUX_INPUT4_ABOVE, .AUX_INPUT5_ABOVE, .LIMIT_SENSE_SELECT_A,
    .LIMIT_SENSE_SELECT_B, .AUX_INPUT5_RAW, .RECORD_WRITTEN, .RECORD_ERASED,
    .COORD_ADDR_CFG, .REG_ADDR, .REG_RD, .REG_RDATA, .REG_RVALID, .RECORD_MEM_FULL,
    .COORD_BUS_ADDRESS, .COORD_ADDR_VALID);

  // Compare one byte and count it
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One read, then a masked compare of the returned byte
  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge SYS_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1;
    chk({7'h00, REG_RVALID}, 8'h01);
    chk(REG_RDATA & m, e);
  endtask : rc

  // Back-to-back record writes, one per edge
  task automatic wr(input int n);
    @(posedge SYS_CLK);
    RECORD_WRITTEN <= 1'b1;
    repeat (n) @(posedge SYS_CLK);
    RECORD_WRITTEN <= 1'b0;
  endtask : wr

  // Counts, verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // 100 MHz clock
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  // Watchdog, several times the expected run of about 270 cycles
  initial begin
    repeat (5000) @(posedge SYS_CLK);
    n_fail++;
    stop_test;
  end

  // Main sequence
  initial begin
    {RST_N, REG_RD, RECORD_WRITTEN, RECORD_ERASED, AUX_INPUT5_RAW} = 5'h00;
    REG_ADDR = 8'h00;
    COORD_ADDR_CFG = 4'h0;
    above_v = 10'h000;
    sense_v = 2'b11;
    repeat (10) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    foreach (rows[i]) begin
      @(posedge SYS_CLK);
      sense_v <= rows[i].sense;
      above_v <= rows[i].above;
      repeat (5) @(posedge SYS_CLK);
      rc(`FRS_OFF_STATUS_FOUR, 8'hFE, rows[i].s4);
      rc(`FRS_OFF_STATUS_FIVE, 8'hFF, rows[i].s5);
    end
    $display("test limit flags done");
    // Pulse one cycle short of the filter, then a long level
    @(posedge SYS_CLK);
    AUX_INPUT5_RAW <= 1'b1;
    repeat (FILT - 1) @(posedge SYS_CLK);
    AUX_INPUT5_RAW <= 1'b0;
    rc(`FRS_OFF_STATUS_FOUR, 8'h01, 8'h00);
    @(posedge SYS_CLK);
    AUX_INPUT5_RAW <= 1'b1;
    repeat (FILT + 1) @(posedge SYS_CLK);
    rc(`FRS_OFF_STATUS_FOUR, 8'h01, 8'h01);
    $display("test logic input done");
    rc(`FRS_OFF_NEXT_PTR, 8'hFF, 8'h80);
    rc(`FRS_OFF_NEXT_PTR, 8'hFF, 8'h80);
    for (int i = 1; i < 16; i++) begin
      wr(1);
      rc(`FRS_OFF_NEXT_PTR, 8'hFF, 8'h80 + 8'(i * 8));
    end
    wr(2);
    rc(`FRS_OFF_NEXT_PTR, 8'hFF, 8'h00);
    chk({7'h00, RECORD_MEM_FULL}, 8'h01);
    @(posedge SYS_CLK);
    RECORD_ERASED <= 1'b1;
    @(posedge SYS_CLK);
    RECORD_ERASED <= 1'b0;
    rc(`FRS_OFF_NEXT_PTR, 8'hFF, 8'h80);
    chk({7'h00, RECORD_MEM_FULL}, 8'h00);
    wr(3);
    @(posedge SYS_CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    // Read port and filtered input must come out of reset cleared
    #1;
    chk(REG_RDATA, `FRS_RDATA_RST);
    chk({7'h00, REG_RVALID}, 8'h00);
    rc(`FRS_OFF_STATUS_FOUR, 8'h01, 8'h00);
    rc(`FRS_OFF_NEXT_PTR, 8'hFF, 8'h80);
    $display("test record pointer done");
    rc(`FRS_OFF_REVISION, 8'hFF, {FAM_ID, HW_REV});
    rc(8'hF4, 8'hFF, 8'h00);
    $display("test revision done");
    for (int c = 0; c < 16; c++) begin
      @(posedge SYS_CLK);
      COORD_ADDR_CFG <= 4'(c);
      repeat (6) @(posedge SYS_CLK);
      #1;
      chk({3'h0, COORD_ADDR_VALID, COORD_BUS_ADDRESS},
        (c >= 1 && c <= 4) ? 8'(16 + c) : 8'h00);
    end
    $display("test coordination address done");
    stop_test;
  end
endmodule : tb

bind frs_top frs_top_assertions #(.FAMILY_ID(FAMILY_ID), .HW_REVISION(HW_REVISION)) chk_u (
  .SYS_CLK, .RST_N, .HIGH_RAIL_ABOVE, .PRIMARY_RAIL1_ABOVE, .PRIMARY_RAIL2_ABOVE,
  .PRIMARY_RAIL3_ABOVE, .PRIMARY_RAIL4_ABOVE, .AUX_INPUT1_ABOVE, .AUX_INPUT2_ABOVE,
  .AUX_INPUT3_ABOVE, .AUX_INPUT4_ABOVE, .AUX_INPUT5_ABOVE, .LIMIT_SENSE_SELECT_A,
  .LIMIT_SENSE_SELECT_B, .RECORD_WRITTEN, .RECORD_ERASED, .COORD_ADDR_CFG, .REG_ADDR,
  .REG_RD, .REG_RDATA, .REG_RVALID, .RECORD_MEM_FULL, .COORD_BUS_ADDRESS,
  .COORD_ADDR_VALID);
`default_nettype wire
